// >>> verilog/icsc_top.sv
// Operation
// - each 17-bit bus captured on rising or falling clock edge, programmable
// - control word bit 4 reverses the bit order of the input buses
// - each bus has an active-low enable; in gated mode samples taken only while low
// - each enable works in gated or interpolated mode, selectable
// - gated mode takes exactly one sample per clock with enable low
// - buses A, B and D use their own clock or the master clock
// - bus C clock is also the master clock for all processing channels
// - either sync input can update oscillators, reset decimation, restart filters, output
// - each sync input response is individually enabled or disabled per block
// - one master sync output drives sync inputs of all devices, master too
// - optional internal path routes own sync output to own sync inputs
// - active-low reset halts processing and restores register defaults
`timescale 1ns/1ps
`default_nettype none
module icsc_top #(
    parameter int unsigned BUF_DEPTH = icsc_pkg::BUF_DEPTH
) (
    input  wire logic                                        clock,
    input  wire logic                                        rst_n,
    input  wire logic [icsc_pkg::ADDR_W-1:0]                 reg_addr,
    input  wire logic [icsc_pkg::DATA_W-1:0]                 reg_wdata,
    input  wire logic                                        reg_wr,
    input  wire logic                                        reg_rd,
    output var  logic [icsc_pkg::DATA_W-1:0]                 reg_rdata,
    input  wire logic [icsc_pkg::SAMPLE_W-1:0]               bus_a_data,
    input  wire logic [icsc_pkg::SAMPLE_W-1:0]               bus_b_data,
    input  wire logic [icsc_pkg::SAMPLE_W-1:0]               bus_c_data,
    input  wire logic [icsc_pkg::SAMPLE_W-1:0]               bus_d_data,
    input  wire logic                                        bus_a_enable_n,
    input  wire logic                                        bus_b_enable_n,
    input  wire logic                                        bus_c_enable_n,
    input  wire logic                                        bus_d_enable_n,
    input  wire logic                                        bus_a_clock,
    input  wire logic                                        bus_b_clock,
    input  wire logic                                        master_clock,
    input  wire logic                                        bus_d_clock,
    input  wire logic                                        global_sync_in_1,
    input  wire logic                                        global_sync_in_2,
    output var  logic                                        sync_out,
    output var  icsc_pkg::icsc_sample_t [icsc_pkg::NUM_BUSES-1:0] out_sample,
    output var  logic [icsc_pkg::NUM_BUSES-1:0]              out_valid,
    input  wire logic [icsc_pkg::NUM_BUSES-1:0]              out_ready,
    output var  logic                                        proc_tick,
    output var  icsc_pkg::icsc_act_t                         sync_act
);
    import icsc_pkg::*;

    function automatic logic [SAMPLE_W-1:0] bit_rev(input logic [SAMPLE_W-1:0] v);
        logic [SAMPLE_W-1:0] r;
        r = '0;
        for (int k = 0; k < SAMPLE_W; k++) begin
            r[k] = v[SAMPLE_W-1-k];
        end
        return r;
    endfunction : bit_rev

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return (a == off);
    endfunction : addr_is

    // Pin gathering
    wire [NUM_BUSES-1:0]               clk_pin = {bus_d_clock, master_clock,
                                                  bus_b_clock, bus_a_clock};
    wire [NUM_BUSES-1:0]               en_pin  = {bus_d_enable_n, bus_c_enable_n,
                                                  bus_b_enable_n, bus_a_enable_n};
    wire [NUM_BUSES-1:0][SAMPLE_W-1:0] dat_pin = {bus_d_data, bus_c_data,
                                                  bus_b_data, bus_a_data};

    // Registers
    icsc_ctrl_t      ctrl_ff;
    icsc_sync_cfg_t  sync_cfg_ff;
    logic [NUM_BUSES-1:0] ovr_ff;
    logic [DATA_W-1:0]    rdata_ff;

    // Synchronisers: stage 1 is read only by stage 2
    logic [NUM_BUSES-1:0]               clk_s1_ff;
    logic [NUM_BUSES-1:0]               clk_s2_ff;
    logic [NUM_BUSES-1:0]               clk_s3_ff;
    logic [NUM_BUSES-1:0]               en_s1_ff;
    logic [NUM_BUSES-1:0]               en_s2_ff;
    logic [NUM_BUSES-1:0][SAMPLE_W-1:0] dat_s1_ff;
    logic [NUM_BUSES-1:0][SAMPLE_W-1:0] dat_s2_ff;
    logic [1:0]                         sin_s1_ff;
    logic [1:0]                         sin_s2_ff;

    // Sync machinery
    logic [1:0]  sync_old_ff;
    logic [2:0]  sync_cnt_ff;
    logic        sync_out_ff;
    icsc_act_t   act_ff;
    logic        tick_ff;

    // Capture path per bus
    logic [NUM_BUSES-1:0] accept;
    logic [NUM_BUSES-1:0] buf_ready;
    icsc_sample_t [NUM_BUSES-1:0] cap_word;

    // Register port decoding
    wire wr_ctrl   = reg_wr & addr_is(reg_addr, REG_CTRL);
    wire wr_cfg    = reg_wr & addr_is(reg_addr, REG_SYNC_CFG);
    wire wr_cmd    = reg_wr & addr_is(reg_addr, REG_SYNC_CMD);
    wire wr_stat   = reg_wr & addr_is(reg_addr, REG_STATUS);
    wire sync_fire = wr_cmd & reg_wdata[CMD_FIRE_BIT];

    // Reserved fields are forced to zero on write
    wire icsc_ctrl_t     wr_ctrl_val = icsc_ctrl_t'(reg_wdata & 16'hFF1F);
    wire icsc_sync_cfg_t wr_cfg_val  = icsc_sync_cfg_t'(reg_wdata & 16'h01FF);

    // Overrun clear by writing ones; a same-cycle overrun still sets
    wire [NUM_BUSES-1:0] ovr_clr = wr_stat ? reg_wdata[STAT_OVR_LSB +: NUM_BUSES] : '0;
    wire [NUM_BUSES-1:0] ovr_set = accept & ~buf_ready;
    wire [NUM_BUSES-1:0] nxt_ovr = (ovr_ff & ~ovr_clr) | ovr_set;

    wire [DATA_W-1:0] status_word = DATA_W'({sync_out_ff, sin_s2_ff[1], sin_s2_ff[0],
                                             out_valid, ovr_ff});

    wire [DATA_W-1:0] rd_mux =
        addr_is(reg_addr, REG_CTRL)     ? DATA_W'(ctrl_ff)     :
        addr_is(reg_addr, REG_SYNC_CFG) ? DATA_W'(sync_cfg_ff) :
        addr_is(reg_addr, REG_SYNC_CMD) ? DATA_W'(sync_out_ff) :
        addr_is(reg_addr, REG_STATUS)   ? status_word          : '0;
    wire [DATA_W-1:0] nxt_rdata = reg_rd ? rd_mux : '0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= icsc_ctrl_t'(CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_ff <= wr_ctrl_val;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_cfg_ff <= icsc_sync_cfg_t'(SYNC_CFG_RST);
        end else if (wr_cfg) begin
            sync_cfg_ff <= wr_cfg_val;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovr_ff <= '0;
        end else begin
            ovr_ff <= nxt_ovr;
        end
    end

    // Read data fall back to zero outside the answer cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Pins cross into the clock domain through two stages
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_s1_ff <= '0;
            clk_s2_ff <= '0;
            clk_s3_ff <= '0;
        end else begin
            clk_s1_ff <= clk_pin;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
        end
    end

    // Enables reset high, so nothing is taken before the pins are seen
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_s1_ff <= '1;
            en_s2_ff <= '1;
        end else begin
            en_s1_ff <= en_pin;
            en_s2_ff <= en_s1_ff;
        end
    end

    // Data words are read only at a detected edge, long after they settle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dat_s1_ff <= '0;
            dat_s2_ff <= '0;
        end else begin
            dat_s1_ff <= dat_pin;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sin_s1_ff <= '0;
            sin_s2_ff <= '0;
        end else begin
            sin_s1_ff <= {global_sync_in_2, global_sync_in_1};
            sin_s2_ff <= sin_s1_ff;
        end
    end

    // Data and enable share the clock's delay, so the word seen at an edge
    // is the word on the pins at that edge; the link clock must stay well
    // below the sampling rate for this to hold
    for (genvar i = 0; i < NUM_BUSES; i++) begin : g_bus
        wire use_master = (i == MASTER_IDX) || ctrl_ff.clk_master[i];
        wire lvl_now    = use_master ? clk_s2_ff[MASTER_IDX] : clk_s2_ff[i];
        wire lvl_old    = use_master ? clk_s3_ff[MASTER_IDX] : clk_s3_ff[i];
        wire edge_hit   = ctrl_ff.fall_edge[i] ? (~lvl_now & lvl_old)
                                               : (lvl_now & ~lvl_old);
        wire en_low     = ~en_s2_ff[i];
        wire [SAMPLE_W-1:0] ordered = ctrl_ff.bit_reverse ? bit_rev(dat_s2_ff[i])
                                                          : dat_s2_ff[i];

        assign accept[i]   = edge_hit & (en_low | ctrl_ff.interp[i]);
        // Interpolated mode stuffs a zero word while the enable is high
        assign cap_word[i] = '{zero_fill: ~en_low,
                               data:      en_low ? ordered : '0};

        // A full buffer cannot stall the pins; the word is dropped and flagged
        icsc_fifo #(
            .WIDTH ($bits(icsc_sample_t)),
            .DEPTH (BUF_DEPTH)
        ) u_buf (
            .clock     (clock),
            .rst_n     (rst_n),
            .in_valid  (accept[i]),
            .in_ready  (buf_ready[i]),
            .in_data   (cap_word[i]),
            .out_valid (out_valid[i]),
            .out_ready (out_ready[i]),
            .out_data  (out_sample[i])
        );
    end

    wire m_now       = clk_s2_ff[MASTER_IDX];
    wire m_old       = clk_s3_ff[MASTER_IDX];
    wire master_edge = ctrl_ff.fall_edge[MASTER_IDX] ? (~m_now & m_old) : (m_now & ~m_old);

    wire [1:0] sync_lvl  = sync_cfg_ff.loopback ? {2{sync_out_ff}} : sin_s2_ff;
    wire [1:0] sync_rise = sync_lvl & ~sync_old_ff;

    wire icsc_act_t nxt_act = icsc_act_t'(({4{sync_rise[0]}} & sync_cfg_ff.in1_en) |
                                          ({4{sync_rise[1]}} & sync_cfg_ff.in2_en));

    wire [2:0] nxt_sync_cnt = sync_fire            ? SYNC_OUT_CYCLES :
                              (sync_cnt_ff != '0)  ? sync_cnt_ff - 3'h1 : '0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_old_ff <= '0;
        end else begin
            sync_old_ff <= sync_lvl;
        end
    end

    // A fire during a running pulse restarts the count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_cnt_ff <= '0;
            sync_out_ff <= 1'b0;
        end else begin
            sync_cnt_ff <= nxt_sync_cnt;
            sync_out_ff <= (nxt_sync_cnt != '0);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            act_ff <= '0;
        end else begin
            act_ff <= nxt_act;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= master_edge;
        end
    end

    assign reg_rdata = rdata_ff;
    assign sync_out  = sync_out_ff;
    assign sync_act  = act_ff;
    assign proc_tick = tick_ff;

endmodule : icsc_top
`default_nettype wire

// >>> include/icsc_pkg.sv
`default_nettype none
package icsc_pkg;

    // Bus geometry
    localparam int unsigned NUM_BUSES   = 4;
    localparam int unsigned SAMPLE_W    = 17;
    localparam int unsigned MASTER_IDX  = 2;
    localparam int unsigned BUF_DEPTH   = 2;

    // Register port geometry and byte offsets
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 16;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_SYNC_CFG = 8'h04;
    localparam logic [7:0]  REG_SYNC_CMD = 8'h08;
    localparam logic [7:0]  REG_STATUS   = 8'h0C;

    // Field positions not carried by a struct
    localparam int unsigned CMD_FIRE_BIT    = 0;
    localparam int unsigned STAT_OVR_LSB    = 0;
    localparam int unsigned STAT_VALID_LSB  = 4;
    localparam int unsigned STAT_SYNC1_BIT  = 8;
    localparam int unsigned STAT_SYNC2_BIT  = 9;
    localparam int unsigned STAT_BUSY_BIT   = 10;

    // Values after reset
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] SYNC_CFG_RST = 16'h00FF;

    // Width of the sync_out pulse in clock cycles
    localparam logic [2:0]  SYNC_OUT_CYCLES = 3'h4;

    // Control word; bit_reverse sits at bit 4
    typedef struct packed {
        logic [3:0] interp;
        logic [3:0] clk_master;
        logic [2:0] rsvd;
        logic       bit_reverse;
        logic [3:0] fall_edge;
    } icsc_ctrl_t;

    // Actions that a synchronization event may trigger
    typedef struct packed {
        logic output_restart;
        logic filter_restart;
        logic decim_reset;
        logic carrier_update;
    } icsc_act_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic       loopback;
        icsc_act_t  in2_en;
        icsc_act_t  in1_en;
    } icsc_sync_cfg_t;

    // One captured word; zero_fill marks a stuffed sample
    typedef struct packed {
        logic                zero_fill;
        logic [SAMPLE_W-1:0] data;
    } icsc_sample_t;

endpackage : icsc_pkg
`default_nettype wire

// >>> verilog/icsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module icsc_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [CW-1:0]    count_ff;
    logic             ready_ff;
    logic             valid_ff;

    wire            push     = in_valid & ready_ff;
    wire            pop      = valid_ff & out_ready;
    wire [CW-1:0]   wpos     = count_ff - CW'(pop);
    wire [CW-1:0]   nxt_cnt  = count_ff + CW'(push) - CW'(pop);

    // Head always sits in slot 0, so the output needs no read mux
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_ff[k] <= '0;
            end
        end else begin
            for (int k = 0; k < DEPTH; k++) begin
                if (pop && (k + 1 < DEPTH)) begin
                    mem_ff[k] <= mem_ff[k + 1];
                end
                if (push && (wpos == CW'(k))) begin
                    mem_ff[k] <= in_data;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
            ready_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            count_ff <= nxt_cnt;
            ready_ff <= (nxt_cnt != FULL_CNT);
            valid_ff <= (nxt_cnt != '0);
        end
    end

    assign in_ready  = ready_ff;
    assign out_valid = valid_ff;
    assign out_data  = mem_ff[0];

endmodule : icsc_fifo
`default_nettype wire

// >>> sim/icsc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module icsc_top_checker (
    input wire logic                                        clock,
    input wire logic                                        rst_n,
    input wire logic [icsc_pkg::ADDR_W-1:0]                 reg_addr,
    input wire logic [icsc_pkg::DATA_W-1:0]                 reg_wdata,
    input wire logic                                        reg_wr,
    input wire logic                                        reg_rd,
    input wire logic [icsc_pkg::DATA_W-1:0]                 reg_rdata,
    input wire logic                                        master_clock,
    input wire logic                                        global_sync_in_1,
    input wire logic                                        global_sync_in_2,
    input wire logic                                        sync_out,
    input wire logic [icsc_pkg::NUM_BUSES-1:0]              out_valid,
    input wire logic [icsc_pkg::NUM_BUSES-1:0]              out_ready,
    input wire logic                                        proc_tick,
    input wire icsc_pkg::icsc_act_t                         sync_act
);
    import icsc_pkg::*;
    logic       mc_q_ff;
    logic [2:0] mc_age_ff;
    // Age since the master clock pin moved; saturates so idle links read as old
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mc_q_ff   <= 1'b0;
            mc_age_ff <= 3'h7;
        end else begin
            mc_q_ff   <= master_clock;
            mc_age_ff <= (master_clock != mc_q_ff) ? 3'h0 : mc_age_ff + 3'(mc_age_ff != 3'h7);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_fire;
        reg_wr && reg_addr == REG_SYNC_CMD && reg_wdata[CMD_FIRE_BIT];
    endsequence
    sequence s_hold4;
        sync_out [*4];
    endsequence
    AST_RDATA_IDLE: assert property (reg_rdata != '0 |-> $past(reg_rd))
        else $error("read data outside a read slot");
    AST_SYNC_FIRE: assert property (s_fire |=> s_hold4)
        else $error("sync_out pulse too short");
    AST_SYNC_CAUSE: assert property ($rose(sync_out) |-> $past(reg_wr))
        else $error("sync_out rose without a write");
    AST_ACT_CAUSE: assert property (sync_act != '0 |->
        ($past(global_sync_in_1, 3) && !$past(global_sync_in_1, 4)) ||
        ($past(global_sync_in_2, 3) && !$past(global_sync_in_2, 4)) ||
        ($past(sync_out) && !$past(sync_out, 2)))
        else $error("action without a sync edge");
    AST_ACT_ONE: assert property (sync_act != '0 |=> sync_act == '0)
        else $error("action pulse longer than one cycle");
    AST_TICK_ONE: assert property (proc_tick |=> !proc_tick)
        else $error("tick longer than one cycle");
    AST_TICK_CAUSE: assert property (proc_tick |-> mc_age_ff <= 3'h5)
        else $error("tick without a master clock edge");
    AST_VALID_CAUSE: assert property ($rose(out_valid[MASTER_IDX]) |-> mc_age_ff <= 3'h5)
        else $error("bus C word without a clock edge");
    AST_VALID_HOLD: assert property ((out_valid & ~out_ready) != '0 |=>
        (out_valid & $past(out_valid & ~out_ready)) == $past(out_valid & ~out_ready))
        else $error("stalled word vanished");
endmodule : icsc_top_checker
bind icsc_top icsc_top_checker checker_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_clock(master_clock),
    .global_sync_in_1(global_sync_in_1), .global_sync_in_2(global_sync_in_2),
    .sync_out(sync_out), .out_valid(out_valid), .out_ready(out_ready),
    .proc_tick(proc_tick), .sync_act(sync_act)
);
`default_nettype wire

// >>> sim/icsc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module icsc_src_model (
    input  wire logic                                  start,
    input  wire logic [3:0]                            clk_on,
    input  wire logic [3:0]                            en_n_set,
    output var  logic [3:0]                            link_clk,
    output var  logic [3:0][icsc_pkg::SAMPLE_W-1:0]    data,
    output var  logic [3:0]                            en_n,
    output var  logic                                  busy
);
    import icsc_pkg::*;
    initial begin
        link_clk = 4'h0;
        data = '0;
        en_n = 4'h0;
        busy = 1'b0;
    end
    // Word changes midway between edges, so each edge sees a different word
    always @(posedge start) begin
        // Offset keeps every pin change clear of the sampling clock edge
        #3;
        busy = 1'b1;
        en_n = en_n_set;
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 4; i++) data[i] = {2'(i), 15'(k)};
            #40;
            link_clk = k[0] ? 4'h0 : clk_on;
            #40;
        end
        // Released pins fall to their pull-downs; clocks stand still
        data = '0;
        en_n = 4'h0;
        busy = 1'b0;
    end
endmodule : icsc_src_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        n_mismatch++; \
    end \
end
module testbench;
    import icsc_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d;} icsc_row_t;
    logic                       clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                       start = 1'b0, global_sync_in_1 = 1'b0, global_sync_in_2 = 1'b0;
    logic [7:0]                 reg_addr = '0;
    logic [15:0]                reg_wdata = '0, reg_rdata, rd_v;
    logic [3:0]                 clk_on = '0, en_set = '0, out_ready = 4'hF, acc;
    logic [3:0]                 link_clk, en_n, out_valid;
    logic [3:0][SAMPLE_W-1:0]   bus_data;
    logic                       sync_out, proc_tick, busy;
    icsc_sample_t [3:0]         out_sample;
    icsc_act_t                  sync_act;
    icsc_sample_t               got[4][$];
    int                         n_mismatch = 0, n_compared = 0, n_tick = 0;
    icsc_row_t rows[10] = '{'{0, REG_CTRL, 16'h0000}, '{0, REG_SYNC_CFG, 16'h00FF},
        '{0, REG_STATUS, 16'h0000}, '{1, REG_CTRL, 16'hBBFF}, '{0, REG_CTRL, 16'hBB1F},
        '{1, REG_SYNC_CFG, 16'hFFFF}, '{0, REG_SYNC_CFG, 16'h01FF}, '{1, 8'h10, 16'hFFFF},
        '{0, 8'h10, 16'h0000}, '{0, REG_SYNC_CMD, 16'h0000}};
    always #5 clock = ~clock;
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) if (out_valid[i] && out_ready[i]) got[i].push_back(out_sample[i]);
        if (proc_tick) n_tick++;
    end
    icsc_top DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_a_data(bus_data[0]),
        .bus_b_data(bus_data[1]), .bus_c_data(bus_data[2]), .bus_d_data(bus_data[3]),
        .bus_a_enable_n(en_n[0]), .bus_b_enable_n(en_n[1]), .bus_c_enable_n(en_n[2]),
        .bus_d_enable_n(en_n[3]), .bus_a_clock(link_clk[0]), .bus_b_clock(link_clk[1]),
        .master_clock(link_clk[2]), .bus_d_clock(link_clk[3]),
        .global_sync_in_1(global_sync_in_1), .global_sync_in_2(global_sync_in_2),
        .sync_out(sync_out), .out_sample(out_sample), .out_valid(out_valid),
        .out_ready(out_ready), .proc_tick(proc_tick), .sync_act(sync_act));
    icsc_src_model SRC (.start(start), .clk_on(clk_on), .en_n_set(en_set),
        .link_clk(link_clk), .data(bus_data), .en_n(en_n), .busy(busy));
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Three link periods per frame; the bounded wait guards a stuck model
    task automatic frame(input logic [15:0] ctrl, input logic [3:0] con, input logic [3:0] en);
        wr(REG_CTRL, ctrl);
        clk_on <= con;
        en_set <= en;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        for (int t = 0; t < 200 && busy; t++) @(posedge clock);
        `CHK(busy, 1'b0)
        repeat (10) @(posedge clock);
    endtask : frame
    task automatic chk_bus(input int i, input int n, input int fall, input logic rev, input logic zf);
        icsc_sample_t e;
        `CHK(got[i].size(), n)
        for (int m = 0; m < got[i].size(); m++) begin
            e.zero_fill = zf;
            e.data = zf ? '0 : {2'(i), 15'(2 * m + fall)};
            if (rev) e.data = {<<{e.data}};
            `CHK(got[i][m], e)
        end
        got[i].delete();
    endtask : chk_bus
    task automatic watch();
        acc = '0;
        repeat (12) begin
            @(posedge clock);
            #1 acc |= sync_act;
        end
    endtask : watch
    task automatic sync_try(input logic [1:0] p, input logic [3:0] exp);
        fork
            begin
                {global_sync_in_2, global_sync_in_1} <= p;
                repeat (4) @(posedge clock);
                {global_sync_in_2, global_sync_in_1} <= 2'b00;
            end
            watch();
        join
        `CHK(acc, exp)
    endtask : sync_try
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[r]) begin
            if (rows[r].wr) wr(rows[r].a, rows[r].d);
            else begin
                rd(rows[r].a, rd_v);
                `CHK(rd_v, rows[r].d)
            end
        end
        // B and D capture on the falling edge
        frame(16'h000A, 4'hF, 4'h0);
        for (int i = 0; i < 4; i++) chk_bus(i, 3, i % 2, 1'b0, 1'b0);
        `CHK(n_tick, 3)
        // Reversed order; A, B, D follow the master clock while their own stand still
        frame(16'h0B10, 4'h4, 4'h0);
        for (int i = 0; i < 4; i++) chk_bus(i, 3, 0, 1'b1, 1'b0);
        frame(16'h4000, 4'hF, 4'h5);
        chk_bus(0, 0, 0, 1'b0, 1'b0);
        chk_bus(1, 3, 0, 1'b0, 1'b0);
        chk_bus(2, 3, 0, 1'b0, 1'b1);
        chk_bus(3, 3, 0, 1'b0, 1'b0);
        // Receiver on D stalls: the newest word is dropped and flagged
        out_ready <= 4'h7;
        frame(16'h0000, 4'hF, 4'h0);
        for (int i = 0; i < 3; i++) got[i].delete();
        rd(REG_STATUS, rd_v);
        `CHK(rd_v, 16'h0088)
        wr(REG_STATUS, 16'h0008);
        rd(REG_STATUS, rd_v);
        `CHK(rd_v, 16'h0080)
        out_ready <= 4'hF;
        repeat (5) @(posedge clock);
        chk_bus(3, 2, 0, 1'b0, 1'b0);
        wr(REG_SYNC_CFG, 16'h0081);
        sync_try(2'b01, 4'h1);
        sync_try(2'b10, 4'h8);
        wr(REG_SYNC_CFG, 16'h0181);
        fork
            begin
                wr(REG_SYNC_CMD, 16'h0001);
                rd(REG_SYNC_CMD, rd_v);
            end
            watch();
        join
        `CHK(rd_v, 16'h0001)
        `CHK(acc, 4'h9)
        wr(REG_CTRL, 16'h0010);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(out_valid, 4'h0)
        rst_n <= 1'b1;
        rd(REG_CTRL, rd_v);
        `CHK(rd_v, 16'h0000)
        results();
    end
endmodule : testbench
`default_nettype wire
